// >>> inc/pso_pkg.sv
/*
 * Package of the power stage output configuration block: register map,
 * field positions, reset values, mode codes and the carrier structs.
 * Assumes a single 125 MHz core clock and an 8-bit register port.
 */
package pso_pkg;

  // ==========================================================
  // Sizes.
  localparam int PSO_UNITS = 3;
  localparam int PSO_CMPS = 4;
  localparam int PSO_PINS = 8;
  localparam int PSO_IRQS = 6;

  // ==========================================================
  // Register map: unit registers sit at unit * PSO_UNIT_STRIDE + offset.
  localparam logic [7:0] PSO_UNIT_STRIDE = 8'h10;
  localparam logic [3:0] PSO_OFS_SYNC_OUT_CFG = 4'h0;
  localparam logic [3:0] PSO_OFS_CONFIG = 4'h1;
  localparam logic [3:0] PSO_OFS_CMP_BASE = 4'h2;
  localparam logic [7:0] PSO_ADDR_IRQ_STATUS = 8'h30;
  localparam logic [7:0] PSO_ADDR_IRQ_MASK = 8'h31;

  // Compare slots; each uses a low byte at base + 2 * slot, high byte next.
  localparam logic [1:0] PSO_CMP_SET_A = 2'h0;
  localparam logic [1:0] PSO_CMP_RESET_A = 2'h1;
  localparam logic [1:0] PSO_CMP_SET_B = 2'h2;
  localparam logic [1:0] PSO_CMP_RESET_B = 2'h3;

  // ==========================================================
  // Field positions of the sync and output configuration register.
  localparam int PSO_BIT_OUT3_SEL = 7;
  localparam int PSO_BIT_OUT2_SEL = 6;
  localparam int PSO_BIT_SYNC_HI = 5;
  localparam int PSO_BIT_SYNC_LO = 4;
  localparam int PSO_BIT_OUT3_EN = 3;
  localparam int PSO_BIT_PART_B_EN = 2;
  localparam int PSO_BIT_OUT2_EN = 1;
  localparam int PSO_BIT_PART_A_EN = 0;
  // Field positions of the configuration register.
  localparam int PSO_BIT_MODE_HI = 4;
  localparam int PSO_BIT_MODE_LO = 3;
  localparam int PSO_CMP_VALUE_W = 12;

  // Reset values.
  localparam logic [7:0] PSO_RST_BYTE = 8'h00;
  localparam logic [15:0] PSO_RST_CMP = 16'h0000;
  localparam logic [5:0] PSO_RST_IRQ = 6'h00;

  // ==========================================================
  // Running modes and sync selections.
  typedef enum logic [1:0] {
    PSO_MODE_ONE_RAMP = 2'b00,
    PSO_MODE_TWO_RAMP = 2'b01,
    PSO_MODE_FOUR_RAMP = 2'b10,
    PSO_MODE_CENTERED = 2'b11
  } pso_mode_t;

  typedef enum logic [1:0] {
    PSO_SYNC_SEL_0 = 2'b00,
    PSO_SYNC_SEL_1 = 2'b01,
    PSO_SYNC_SEL_2 = 2'b10,
    PSO_SYNC_SEL_3 = 2'b11
  } pso_sync_sel_t;

  // Per unit inputs from the waveform engine of the same clock domain.
  typedef struct packed {
    logic [11:0] counter;
    logic count_down;
    logic wave_a;
    logic wave_b;
    logic fault_a;
    logic fault_b;
    logic retrigger;
    logic capture;
    logic sync_error;
  } pso_unit_in_t;

  // Per unit results handed back to the waveform engine.
  typedef struct packed {
    logic [3:0] cmp_match;
    logic [3:0] flank_width;
    logic [1:0] running_mode_field;
  } pso_unit_out_t;

endpackage : pso_pkg

// >>> test/pso_sample_hold.sv
/*
 * Model of the converter sample-and-hold: counts sync pulses per unit.
 * Assumes one-cycle sync pulses on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pso_sample_hold
  import pso_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Sync pulses from the block.
  input wire logic [PSO_UNITS-1:0] i_conv_sync,
  // Conversions started per unit.
  output logic [15:0] o_sync_count [PSO_UNITS]
);
  // ====
  // Counting
  // Every sampled pulse starts one conversion.
  always_ff @(posedge i_core_clk) begin
    for (int u = 0; u < PSO_UNITS; u++) begin
      if (!i_rst_n) begin
        o_sync_count[u] <= 16'h0000;
      end else if (i_conv_sync[u]) begin
        o_sync_count[u] <= o_sync_count[u] + 16'h0001;
      end
    end
  end
endmodule : pso_sample_hold
`default_nettype wire

// >>> test/testbench.sv
/*
 * Self-checking bench of the output configuration block.
 * Assumes the package and the sample-and-hold model.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench
  import pso_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  pso_unit_in_t [PSO_UNITS-1:0] uin;
  pso_unit_out_t [PSO_UNITS-1:0] uout;
  logic [7:0] pout = 8'h00;
  logic [7:0] poe = 8'h00;
  logic [7:0] pin;
  logic [7:0] pin_oe;
  logic [2:0] sync;
  logic irq;
  logic [3:0] vec;
  logic [15:0] scnt [PSO_UNITS];
  logic [7:0] q [$];
  logic rd_seen = 1'b0;
  int err_total = 0;
  int comparisons = 0;

  // ====
  // Design and far side
  pso_output_config pso_output_config_i (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_unit(uin), .o_unit(uout), .i_port_out(pout),
    .i_port_oe(poe), .o_pin_out(pin), .o_pin_oe(pin_oe), .o_conv_sync(sync),
    .o_irq(irq), .o_irq_vector(vec));
  pso_sample_hold pso_sample_hold_i (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_conv_sync(sync), .o_sync_count(scnt));

  // The clock toggles every half period of 4 ns.
  always #4 clk = ~clk;

  // ====
  // Checking
  task automatic chk(input logic [7:0] act, input logic [7:0] exp, input string m);
    comparisons++;
    if (act !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, act, exp);
    end
  endtask : chk

  // Read data stands in the cycle after the strobe; the oldest note is matched.
  always @(posedge clk) begin
    if (rd_seen) begin
      chk(rdata, q.pop_front(), "read data");
    end
    rd_seen <= rd;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(8 * 20000);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // ====
  // Bus and stimulus tasks
  function automatic logic [7:0] ra(input int u, input logic [3:0] o);
    return 8'(u) * PSO_UNIT_STRIDE + {4'h0, o};
  endfunction : ra

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr8

  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd8

  // High byte first, then the low byte commits both in the very next cycle.
  task automatic wcmp(input int u, input int s, input logic [15:0] v);
    @(posedge clk);
    addr <= ra(u, PSO_OFS_CMP_BASE + 4'(2 * s) + 4'h1);
    wdata <= v[15:8];
    wr <= 1'b1;
    @(posedge clk);
    addr <= ra(u, PSO_OFS_CMP_BASE + 4'(2 * s));
    wdata <= v[7:0];
    @(posedge clk);
    wr <= 1'b0;
  endtask : wcmp

  task automatic cnt(input int u, input logic [11:0] v, input logic dn);
    @(posedge clk);
    uin[u].counter <= v;
    uin[u].count_down <= dn;
    @(negedge clk);
  endtask : cnt

  task automatic pulse(input int u, input int k);
    @(posedge clk);
    uin[u][k] <= 1'b1;
    @(posedge clk);
    uin[u][k] <= 1'b0;
    @(negedge clk);
  endtask : pulse

  // Expected pin drive as {enable, level}.
  function automatic logic [15:0] pexp(input logic [7:0] c [3]);
    logic [7:0] s;
    logic [7:0] v;
    for (int u = 0; u < 3; u++) begin
      s[2*u] = c[u][PSO_BIT_PART_A_EN];
      s[2*u+1] = c[u][PSO_BIT_PART_B_EN];
      v[2*u] = uin[u].wave_a;
      v[2*u+1] = uin[u].wave_b;
    end
    s[6] = c[2][PSO_BIT_OUT2_EN];
    s[7] = c[2][PSO_BIT_OUT3_EN];
    v[6] = c[2][PSO_BIT_OUT2_SEL] ? uin[2].wave_b : uin[2].wave_a;
    v[7] = c[2][PSO_BIT_OUT3_SEL] ? uin[2].wave_a : uin[2].wave_b;
    return {s | poe, (s & v) | (~s & pout)};
  endfunction : pexp

  // ====
  // Main sequence
  initial begin
    logic [7:0] c [3];
    logic [15:0] v;
    logic [15:0] n;
    logic e;
    int b;
    void'($urandom(32'hb42f));
    uin = '0;
    for (int u = 0; u < 3; u++) begin
      uin[u].counter = 12'hfff;
    end
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int u = 0; u < 3; u++) begin
      rd8(ra(u, PSO_OFS_SYNC_OUT_CFG), PSO_RST_BYTE);
      rd8(ra(u, PSO_OFS_CONFIG), PSO_RST_BYTE);
      rd8(ra(u, 4'h9), 8'h00);
    end
    rd8(8'hff, 8'h00);
    $display("test registers done");
    repeat (8) begin
      for (int u = 0; u < 3; u++) begin
        c[u] = 8'($urandom);
        wr8(ra(u, PSO_OFS_SYNC_OUT_CFG), c[u]);
        rd8(ra(u, PSO_OFS_SYNC_OUT_CFG), c[u]);
        uin[u].wave_a <= 1'($urandom);
        uin[u].wave_b <= 1'($urandom);
      end
      pout <= 8'($urandom);
      poe <= 8'($urandom);
      repeat (2) @(negedge clk);
      v = pexp(c);
      chk(pin, v[7:0], "pin level");
      chk(pin_oe, v[15:8], "pin enable");
    end
    $display("test pins done");
    wr8(PSO_ADDR_IRQ_STATUS, 8'h3f);
    wr8(PSO_ADDR_IRQ_MASK, 8'h3f);
    rd8(PSO_ADDR_IRQ_MASK, 8'h3f);
    for (int u = 0; u < 3; u++) begin
      b = 5 - 2 * u;
      v = {4'($urandom), 4'h1, 8'(u)};
      wcmp(u, PSO_CMP_RESET_B, v);
      wr8(ra(u, PSO_OFS_CMP_BASE), 8'h55);
      @(negedge clk);
      chk(8'(uout[u].flank_width), 8'(v[15:12]), "flank");
      cnt(u, {v[11:8], 8'h55}, 1'b0);
      chk(8'(uout[u].cmp_match), 8'h01, "shared high byte");
      cnt(u, v[11:0], 1'b0);
      chk(8'(uout[u].cmp_match), 8'h08, "reset B match");
      @(negedge clk);
      chk(8'(irq), 8'h01, "end irq");
      chk(8'(vec), 8'(b + 1), "end vector");
      rd8(PSO_ADDR_IRQ_STATUS, 8'(1 << b));
      wr8(PSO_ADDR_IRQ_STATUS, 8'(1 << b));
      rd8(PSO_ADDR_IRQ_STATUS, 8'h00);
      cnt(u, 12'hfff, 1'b0);
    end
    $display("test end of cycle done");
    for (int u = 0; u < 3; u++) begin
      for (int k = 0; k < 3; k++) begin
        b = 4 - 2 * u;
        pulse(u, k);
        chk(8'(vec), 8'(b + 1), "capture vector");
        rd8(PSO_ADDR_IRQ_STATUS, 8'(1 << b));
        wr8(PSO_ADDR_IRQ_MASK, 8'h00);
        @(negedge clk);
        chk(8'(irq), 8'h00, "masked irq");
        wr8(PSO_ADDR_IRQ_MASK, 8'h3f);
        wr8(PSO_ADDR_IRQ_STATUS, 8'h3f);
      end
    end
    $display("test capture done");
    for (int u = 0; u < 3; u++) begin
      for (int s = 0; s < 4; s++) begin
        wcmp(u, s, 16'(16 * (s + 1)));
      end
      for (int m = 0; m < 4; m++) begin
        wr8(ra(u, PSO_OFS_CONFIG), 8'(m << PSO_BIT_MODE_LO));
        @(negedge clk);
        chk(8'(uout[u].running_mode_field), 8'(m), "mode");
        for (int s = 0; s < 4; s++) begin
          wr8(ra(u, PSO_OFS_SYNC_OUT_CFG), 8'(s << PSO_BIT_SYNC_LO));
          for (int t = 0; t < 8; t++) begin
            n = scnt[u];
            cnt(u, 12'(16 * (t / 2 + 1)), t[0]);
            cnt(u, 12'hfff, t[0]);
            repeat (2) @(negedge clk);
            e = (m == 3) ? (t / 2 == 1 && s < 2 && t[0] == (s == 0)) : (t / 2 == s);
            chk(8'(scnt[u] - n), 8'(e), "sync pulses");
          end
          for (int f = 0; f < 2; f++) begin
            n = scnt[u];
            pulse(u, 4 - f);
            repeat (2) @(negedge clk);
            chk(8'(scnt[u] - n), 8'(m < 3 && s == 2 * f + 1), "fault sync");
          end
        end
      end
    end
    $display("test sync done");
    repeat (3) @(posedge clk);
    results();
  end
endmodule : testbench
`default_nettype wire

// >>> verilog/pso_output_config.sv
/*
 * Output routing, converter sync, compare registers and interrupt
 * requests of three power stage units, behind an 8-bit register port.
 * Assumes the waveform engine runs on the same clock and the register
 * master keeps one-cycle strobes that are never high together.
 */
// What this block does
// - Each unit has two requests; end-of-cycle fires on reset-B compare match.
// - Capture request fires on retrigger, counter capture or sync error.
// - Six requests take vectors 0x0001..0x0006, unit 2 capture first.
// - Unit 2 output 3 takes generator B when select bit 7 clear, else A.
// - Unit 2 output 2 takes generator A when select bit 6 clear, else B.
// - Ramp modes: sync field picks lead or trail edge of output 0 or 1.
// - Leading edge is set match; trailing is reset match or fault.
// - Centered mode: 00 down-count reset-A match, 01 up-count, others none.
// - Unit 2 bit 3 gives output 3 second pin to generator B.
// - Bit 2 gives each unit output 1 pin to generator B.
// - Unit 2 bit 1 gives output 2 second pin to generator A.
// - Bit 0 gives each unit output 0 pin to generator A.
// - Four 12-bit compare values are matched continuously against the counter.
// - Reset-B compare also holds a 4-bit flank width in bits 15:12.
// - Compare writes pass one shared 8-bit temporary high byte.
// - Three identical units; only unit 2 has extra select and enable bits.
// - Mode field codes 00..11 select one, two, four ramp or centered mode.
`timescale 1ns/100ps
`default_nettype none

module pso_output_config
  import pso_pkg::*;
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Waveform engine side.
  input wire pso_unit_in_t [PSO_UNITS-1:0] i_unit,
  output pso_unit_out_t [PSO_UNITS-1:0] o_unit,
  // Ordinary port logic for the eight pins.
  input wire logic [PSO_PINS-1:0] i_port_out,
  input wire logic [PSO_PINS-1:0] i_port_oe,
  // Pins and converter sync.
  output logic [PSO_PINS-1:0] o_pin_out,
  output logic [PSO_PINS-1:0] o_pin_oe,
  output logic [PSO_UNITS-1:0] o_conv_sync,
  // Interrupt.
  output logic o_irq,
  output logic [3:0] o_irq_vector
);

  // ==========================================================
  // Decode helpers.
  // Returns one when the address targets a unit register at the given offset.
  function automatic logic unit_hit(input logic [7:0] addr, input int u,
                                    input logic [3:0] ofs);
    unit_hit = (addr == (PSO_UNIT_STRIDE * 8'(u)) + {4'h0, ofs});
  endfunction : unit_hit
  // Compares the 12-bit compare value with the unit counter.
  function automatic logic cmp_equal(input logic [15:0] cmp, input logic [11:0] cnt);
    cmp_equal = (cmp[PSO_CMP_VALUE_W-1:0] == cnt);
  endfunction : cmp_equal

  // ==========================================================
  // Storage.
  logic [7:0] sync_out_cfg_reg [PSO_UNITS];
  logic [7:0] config_reg [PSO_UNITS];
  logic [15:0] cmp_reg [PSO_UNITS][PSO_CMPS];
  logic [7:0] temp_high_reg;
  logic [3:0] match_prev_reg [PSO_UNITS];
  logic [PSO_IRQS-1:0] irq_status_reg;
  logic [PSO_IRQS-1:0] irq_mask_reg;
  logic [PSO_IRQS-1:0] irq_status_next;
  logic [PSO_IRQS-1:0] irq_event;
  logic [PSO_IRQS-1:0] irq_pending;
  logic [3:0] match_now [PSO_UNITS];
  logic [3:0] match_edge [PSO_UNITS];
  logic [PSO_UNITS-1:0] sync_next;
  logic [PSO_PINS-1:0] pin_out_next;
  logic [PSO_PINS-1:0] pin_oe_next;
  logic [3:0] vector_next;
  logic [7:0] rdata_next;

  // ==========================================================
  // Register writes: configuration bytes and the compare pair path.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      temp_high_reg <= PSO_RST_BYTE;
      for (int u = 0; u < PSO_UNITS; u++) begin
        sync_out_cfg_reg[u] <= PSO_RST_BYTE;
        config_reg[u] <= PSO_RST_BYTE;
        for (int c = 0; c < PSO_CMPS; c++) begin
          cmp_reg[u][c] <= PSO_RST_CMP;
        end
      end
    end else if (i_reg_wr) begin
      for (int u = 0; u < PSO_UNITS; u++) begin
        if (unit_hit(i_reg_addr, u, PSO_OFS_SYNC_OUT_CFG)) begin
          sync_out_cfg_reg[u] <= i_reg_wdata;
        end
        if (unit_hit(i_reg_addr, u, PSO_OFS_CONFIG)) begin
          config_reg[u] <= i_reg_wdata;
        end
        for (int c = 0; c < PSO_CMPS; c++) begin
          // High byte only lands in the shared temporary byte.
          if (unit_hit(i_reg_addr, u, PSO_OFS_CMP_BASE + 4'(2 * c + 1))) begin
            temp_high_reg <= i_reg_wdata;
          end
          // Low byte commits both halves together.
          if (unit_hit(i_reg_addr, u, PSO_OFS_CMP_BASE + 4'(2 * c))) begin
            cmp_reg[u][c] <= {temp_high_reg, i_reg_wdata};
          end
        end
      end
    end
  end

  // ==========================================================
  // Compare matching; an event is the first cycle of a match.
  always_comb begin
    for (int u = 0; u < PSO_UNITS; u++) begin
      for (int c = 0; c < PSO_CMPS; c++) begin
        match_now[u][c] = cmp_equal(cmp_reg[u][c], i_unit[u].counter);
      end
      match_edge[u] = match_now[u] & ~match_prev_reg[u];
    end
  end
  // Remembers the previous match levels for edge detection.
  always_ff @(posedge i_core_clk) begin
    for (int u = 0; u < PSO_UNITS; u++) begin
      if (!i_rst_n) begin
        match_prev_reg[u] <= 4'h0;
      end else begin
        match_prev_reg[u] <= match_now[u];
      end
    end
  end
  // Hands matches, flank width and mode back to the engine.
  always_comb begin
    for (int u = 0; u < PSO_UNITS; u++) begin
      o_unit[u].cmp_match = match_edge[u];
      o_unit[u].flank_width = cmp_reg[u][PSO_CMP_RESET_B][15:12];
      o_unit[u].running_mode_field = config_reg[u][PSO_BIT_MODE_HI:PSO_BIT_MODE_LO];
    end
  end

  // ==========================================================
  // Converter sync pulse selection per unit.
  always_comb begin
    for (int u = 0; u < PSO_UNITS; u++) begin
      case (pso_sync_sel_t'(sync_out_cfg_reg[u][PSO_BIT_SYNC_HI:PSO_BIT_SYNC_LO]))
        PSO_SYNC_SEL_0: begin
          if (pso_mode_t'(config_reg[u][PSO_BIT_MODE_HI:PSO_BIT_MODE_LO]) ==
              PSO_MODE_CENTERED) begin
            sync_next[u] = match_edge[u][PSO_CMP_RESET_A] & i_unit[u].count_down;
          end else begin
            sync_next[u] = match_edge[u][PSO_CMP_SET_A];
          end
        end
        PSO_SYNC_SEL_1: begin
          if (pso_mode_t'(config_reg[u][PSO_BIT_MODE_HI:PSO_BIT_MODE_LO]) ==
              PSO_MODE_CENTERED) begin
            sync_next[u] = match_edge[u][PSO_CMP_RESET_A] & ~i_unit[u].count_down;
          end else begin
            sync_next[u] = match_edge[u][PSO_CMP_RESET_A] | i_unit[u].fault_a;
          end
        end
        PSO_SYNC_SEL_2: begin
          sync_next[u] = match_edge[u][PSO_CMP_SET_B] &
                         (config_reg[u][PSO_BIT_MODE_HI:PSO_BIT_MODE_LO] != PSO_MODE_CENTERED);
        end
        PSO_SYNC_SEL_3: begin
          sync_next[u] = (match_edge[u][PSO_CMP_RESET_B] | i_unit[u].fault_b) &
                         (config_reg[u][PSO_BIT_MODE_HI:PSO_BIT_MODE_LO] != PSO_MODE_CENTERED);
        end
        default: begin
          sync_next[u] = 1'b0;
        end
      endcase
    end
  end
  // Registers the sync pulses.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_conv_sync <= '0;
    end else begin
      o_conv_sync <= sync_next;
    end
  end

  // ==========================================================
  // Pin routing: generator outputs or ordinary port logic.
  always_comb begin
    for (int u = 0; u < PSO_UNITS; u++) begin
      pin_out_next[2 * u] = sync_out_cfg_reg[u][PSO_BIT_PART_A_EN] ?
                            i_unit[u].wave_a : i_port_out[2 * u];
      pin_oe_next[2 * u] = sync_out_cfg_reg[u][PSO_BIT_PART_A_EN] | i_port_oe[2 * u];
      pin_out_next[2 * u + 1] = sync_out_cfg_reg[u][PSO_BIT_PART_B_EN] ?
                                i_unit[u].wave_b : i_port_out[2 * u + 1];
      pin_oe_next[2 * u + 1] = sync_out_cfg_reg[u][PSO_BIT_PART_B_EN] |
                               i_port_oe[2 * u + 1];
    end
    // Unit 2 alone has the second pins of outputs 2 and 3.
    if (sync_out_cfg_reg[2][PSO_BIT_OUT2_EN]) begin
      pin_out_next[6] = sync_out_cfg_reg[2][PSO_BIT_OUT2_SEL] ?
                        i_unit[2].wave_b : i_unit[2].wave_a;
      pin_oe_next[6] = 1'b1;
    end else begin
      pin_out_next[6] = i_port_out[6];
      pin_oe_next[6] = i_port_oe[6];
    end
    if (sync_out_cfg_reg[2][PSO_BIT_OUT3_EN]) begin
      pin_out_next[7] = sync_out_cfg_reg[2][PSO_BIT_OUT3_SEL] ?
                        i_unit[2].wave_a : i_unit[2].wave_b;
      pin_oe_next[7] = 1'b1;
    end else begin
      pin_out_next[7] = i_port_out[7];
      pin_oe_next[7] = i_port_oe[7];
    end
  end
  // Registers the pin drive.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pin_out <= '0;
      o_pin_oe <= '0;
    end else begin
      o_pin_out <= pin_out_next;
      o_pin_oe <= pin_oe_next;
    end
  end

  // ==========================================================
  // Interrupts: bit 2k is capture and bit 2k+1 end of cycle of unit 2-k.
  always_comb begin
    for (int u = 0; u < PSO_UNITS; u++) begin
      irq_event[2 * (2 - u)] = i_unit[u].retrigger | i_unit[u].capture |
                               i_unit[u].sync_error;
      irq_event[2 * (2 - u) + 1] = match_edge[u][PSO_CMP_RESET_B];
    end
    irq_status_next = irq_status_reg;
    if (i_reg_wr && i_reg_addr == PSO_ADDR_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~i_reg_wdata[PSO_IRQS-1:0];
    end
    // A new event wins over a clear in the same cycle.
    irq_status_next = irq_status_next | irq_event;
  end
  // Holds the sticky status and the mask.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_status_reg <= PSO_RST_IRQ;
      irq_mask_reg <= PSO_RST_IRQ;
    end else begin
      irq_status_reg <= irq_status_next;
      if (i_reg_wr && i_reg_addr == PSO_ADDR_IRQ_MASK) begin
        irq_mask_reg <= i_reg_wdata[PSO_IRQS-1:0];
      end
    end
  end
  // Picks the lowest pending vector slot, starting at one.
  assign irq_pending = irq_status_reg & irq_mask_reg;
  assign o_irq = |irq_pending;
  always_comb begin
    vector_next = 4'h0;
    for (int k = PSO_IRQS - 1; k >= 0; k--) begin
      if (irq_pending[k]) begin
        vector_next = 4'(k + 1);
      end
    end
  end
  assign o_irq_vector = vector_next;

  // ==========================================================
  // Read data, valid in the cycle after the read strobe.
  always_comb begin
    rdata_next = 8'h00;
    for (int u = 0; u < PSO_UNITS; u++) begin
      if (unit_hit(i_reg_addr, u, PSO_OFS_SYNC_OUT_CFG)) begin
        rdata_next = sync_out_cfg_reg[u];
      end
      if (unit_hit(i_reg_addr, u, PSO_OFS_CONFIG)) begin
        rdata_next = config_reg[u];
      end
    end
    if (i_reg_addr == PSO_ADDR_IRQ_STATUS) begin
      rdata_next = {2'b00, irq_status_reg};
    end
    if (i_reg_addr == PSO_ADDR_IRQ_MASK) begin
      rdata_next = {2'b00, irq_mask_reg};
    end
  end
  // Registers the read answer; zero outside a read.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= i_reg_rd ? rdata_next : 8'h00;
    end
  end

  // ==========================================================
  // Checks.
  sequence s_high_write;
    i_reg_wr && i_reg_addr == PSO_UNIT_STRIDE * 8'd0 + 8'h09;
  endsequence
  sequence s_low_write;
    i_reg_wr && i_reg_addr == PSO_UNIT_STRIDE * 8'd0 + 8'h08;
  endsequence
  property p_pair_commit;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    s_high_write ##1 s_low_write |=>
      cmp_reg[0][PSO_CMP_RESET_B] == {$past(i_reg_wdata, 2), $past(i_reg_wdata)};
  endproperty
  a_pair_commit: assert property (p_pair_commit) else $error("pair commit wrong");
  property p_ec_sets;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    match_edge[0][PSO_CMP_RESET_B] |=> irq_status_reg[5];
  endproperty
  a_ec_sets: assert property (p_ec_sets) else $error("end of cycle flag missed");
  property p_capture_event_irq_sets;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_unit[2].sync_error |=> irq_status_reg[0];
  endproperty
  a_capture_event_irq_sets: assert property (p_capture_event_irq_sets) else $error("capture flag missed");
  property p_vector;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    irq_pending[4] && irq_pending[3:0] == 4'h0 |-> o_irq && o_irq_vector == 4'h5;
  endproperty
  a_vector: assert property (p_vector) else $error("vector slot wrong");
  property p_out3_route;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    sync_out_cfg_reg[2][PSO_BIT_OUT3_EN] && !sync_out_cfg_reg[2][PSO_BIT_OUT3_SEL] |=>
      o_pin_out[7] == $past(i_unit[2].wave_b) && o_pin_oe[7];
  endproperty
  a_out3_route: assert property (p_out3_route) else $error("output 3 route wrong");
  property p_out2_route;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    sync_out_cfg_reg[2][PSO_BIT_OUT2_EN] && sync_out_cfg_reg[2][PSO_BIT_OUT2_SEL] |=>
      o_pin_out[6] == $past(i_unit[2].wave_b);
  endproperty
  a_out2_route: assert property (p_out2_route) else $error("output 2 route wrong");
  property p_pin_release;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !sync_out_cfg_reg[1][PSO_BIT_PART_A_EN] |=>
      o_pin_oe[2] == $past(i_port_oe[2]) && o_pin_out[2] == $past(i_port_out[2]);
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin not released");
  property p_center_quiet;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    config_reg[0][PSO_BIT_MODE_HI:PSO_BIT_MODE_LO] == PSO_MODE_CENTERED &&
      sync_out_cfg_reg[0][PSO_BIT_SYNC_HI] |=> !o_conv_sync[0];
  endproperty
  a_center_quiet: assert property (p_center_quiet) else $error("centered sync leaked");
  property p_lead_sync;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    config_reg[1][PSO_BIT_MODE_HI] == 1'b0 &&
      sync_out_cfg_reg[1][PSO_BIT_SYNC_HI:PSO_BIT_SYNC_LO] == 2'b10 &&
      match_edge[1][PSO_CMP_SET_B] |=> o_conv_sync[1];
  endproperty
  a_lead_sync: assert property (p_lead_sync) else $error("leading sync missed");
endmodule : pso_output_config

`default_nettype wire
